// File: design/ive_top.sv
// Purpose: Input value range encoder for the 1 V to 5 V voltage channels.
// Assumes: Samples arrive as strobes on core_clk; load and run come from pins.
// Notes: Output words change only at the conversion cycle tick.
module ive_top #(
  parameter int NCH = 2,
  parameter int RAW_W = 24,
  parameter int SPAN_BITS = 16,
  parameter logic signed [RAW_W-1:0] RAW_ZERO = 24'sh004000,
  parameter int CYCLE_CLKS = ive_pkg::CONV_CYCLE_CLKS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Converter samples.
  input wire logic [NCH-1:0] smp_valid,
  input wire logic [NCH*RAW_W-1:0] smp_raw,
  input wire logic [NCH-1:0] smp_wire_break,
  output logic conv_start,
  // System pins.
  input wire logic load_missing_pin,
  input wire logic ctrl_run_pin,
  // Input words toward the controller.
  output logic [NCH*16-1:0] in_word,
  output logic word_update,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt.
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic load_meta;
  logic load_missing;
  logic run_meta;
  logic ctrl_run;
  logic [15:0] cyc_cnt;
  logic tick;
  logic [31:0] ctrl;
  logic [31:0] mask;
  logic [31:0] status;
  logic [31:0] next_status;
  logic [31:0] ev_set;
  ive_pkg::ive_pstate_t pstate;
  logic commit;
  logic [NCH-1:0] fresh;
  logic [NCH-1:0] pend_have;
  logic [NCH*RAW_W-1:0] pend_raw;
  logic [NCH-1:0] pend_wb;
  logic [NCH*16-1:0] enc_code;
  logic [NCH-1:0] enc_open;
  logic [NCH-1:0] enc_low;
  logic [NCH-1:0] enc_high;
  logic [31:0] next_rdata;

  // Pick one 16-bit word out of a flat vector of words.
  function automatic logic [15:0] ive_word(input logic [NCH*16-1:0] vec, input int idx);
    ive_word = vec[idx*16 +: 16];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Load supply state arrives from the power module, outside this clock.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      load_meta <= 1'b1;
      load_missing <= 1'b1;
    end else begin
      load_meta <= load_missing_pin;
      load_missing <= load_meta;
    end
  end

  // Controller run state is only reported; it never gates the words.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_meta <= 1'b0;
      ctrl_run <= 1'b0;
    end else begin
      run_meta <= ctrl_run_pin;
      ctrl_run <= run_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion cycle timer.

  // The timer runs free whatever channels are enabled, so disabling a
  // channel never shortens the cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cyc_cnt <= 16'h0000;
    end else if (tick) begin
      cyc_cnt <= 16'h0000;
    end else begin
      cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end

  assign tick = (cyc_cnt == 16'(CYCLE_CLKS - 1));

  // A start pulse tells the converter a new cycle begins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Channel enables and diagnostic enables.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= ive_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == ive_pkg::ADDR_CTRL) begin
      ctrl <= reg_wdata;
    end
  end

  // Interrupt mask, same layout as the status register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask <= ive_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == ive_pkg::ADDR_MASK) begin
      mask <= reg_wdata;
    end
  end

  assign commit = reg_wr && (reg_addr == ive_pkg::ADDR_PARAM)
                  && reg_wdata[ive_pkg::PARAM_COMMIT_POS];

  // Parameter assignment state; nothing is delivered until a valid set
  // has been committed.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pstate <= ive_pkg::IVE_UNASSIGNED;
    end else if (commit) begin
      case (reg_wdata[ive_pkg::PARAM_BAD_POS])
        1'b1: pstate <= ive_pkg::IVE_INVALID;
        default: pstate <= ive_pkg::IVE_ASSIGNED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample capture.

  // The newest sample of each channel waits for the next tick; a later
  // sample in the same cycle replaces an earlier one. A commit drops what
  // waits, since it was converted before the new assignment.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_have <= '0;
      pend_raw <= '0;
      pend_wb <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (smp_valid[i]) begin
          pend_have[i] <= 1'b1;
          pend_raw[i*RAW_W +: RAW_W] <= smp_raw[i*RAW_W +: RAW_W];
          pend_wb[i] <= smp_wire_break[i];
        end else if (tick || commit) begin
          pend_have[i] <= 1'b0;
        end
      end
    end
  end

  // A channel becomes fresh with its first conversion after startup or
  // after a commit; a sample arriving with the commit still counts later.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fresh <= '0;
    end else if (commit) begin
      fresh <= '0;
    end else if (tick) begin
      fresh <= fresh | pend_have;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Encoding.

  // One scaler per channel works on the captured sample.
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    ive_scale #(
      .RAW_W(RAW_W),
      .SPAN_BITS(SPAN_BITS)
    ) u_scale (
      .raw($signed(pend_raw[g*RAW_W +: RAW_W])),
      .zero(RAW_ZERO),
      .wire_break(pend_wb[g]),
      .wb_diag_en(ctrl[ive_pkg::CTRL_WB_DIAG_POS]),
      .lim_diag_en(ctrl[ive_pkg::CTRL_LIM_DIAG_POS]),
      .code(enc_code[g*16 +: 16]),
      .ev_open(enc_open[g]),
      .ev_low(enc_low[g]),
      .ev_high(enc_high[g])
    );
  end

  // Words load only at the tick and hold in between. Substitution order:
  // missing load, parameters, disabled channel, no fresh conversion.
  // The run state is deliberately not a term here.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_word <= {NCH{ive_pkg::CODE_SUBST}};
    end else if (tick) begin
      for (int i = 0; i < NCH; i++) begin
        if (load_missing) begin
          in_word[i*16 +: 16] <= ive_pkg::CODE_SUBST;
        end else if (pstate != ive_pkg::IVE_ASSIGNED) begin
          in_word[i*16 +: 16] <= ive_pkg::CODE_SUBST;
        end else if (!ctrl[ive_pkg::CTRL_EN_POS + i]) begin
          in_word[i*16 +: 16] <= ive_pkg::CODE_SUBST;
        end else if (!(fresh[i] || pend_have[i]) || commit) begin
          in_word[i*16 +: 16] <= ive_pkg::CODE_SUBST;
        end else if (pend_have[i]) begin
          in_word[i*16 +: 16] <= ive_word(enc_code, i);
        end
      end
    end
  end

  // Pulse that marks a fresh set of words.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_update <= 1'b0;
    end else begin
      word_update <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic events and interrupt.

  // Events count only for a channel that really delivers a new value.
  always_comb begin
    ev_set = 32'h0000_0000;
    if (tick && !load_missing && pstate == ive_pkg::IVE_ASSIGNED && !commit) begin
      for (int i = 0; i < NCH; i++) begin
        if (pend_have[i] && ctrl[ive_pkg::CTRL_EN_POS + i]) begin
          ev_set[ive_pkg::STAT_OPEN_POS + i] = enc_open[i];
          ev_set[ive_pkg::STAT_LOW_POS + i] = enc_low[i];
          ev_set[ive_pkg::STAT_HIGH_POS + i] = enc_high[i];
        end
      end
    end
  end

  // Write-one-to-clear; an event in the clearing cycle still sets.
  always_comb begin
    next_status = status;
    if (reg_wr && reg_addr == ive_pkg::ADDR_STATUS) begin
      next_status = status & ~reg_wdata;
    end
    next_status = next_status | ev_set;
  end

  // Sticky diagnostic flags.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= 32'h0000_0000;
    end else begin
      status <= next_status;
    end
  end

  // Level interrupt while any unmasked flag stands.
  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // Register read-back.

  // Read data are registered so they stand in the cycle after the strobe;
  // unmapped offsets read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      ive_pkg::ADDR_CTRL: next_rdata = ctrl;
      ive_pkg::ADDR_PARAM: next_rdata = 32'h0000_0000;
      ive_pkg::ADDR_STATUS: next_rdata = status;
      ive_pkg::ADDR_MASK: next_rdata = mask;
      ive_pkg::ADDR_STATE: begin
        next_rdata[ive_pkg::STATE_LOAD_POS] = !load_missing;
        next_rdata[ive_pkg::STATE_RUN_POS] = ctrl_run;
        next_rdata[ive_pkg::STATE_PSTATE_POS +: 2] = pstate;
        next_rdata[ive_pkg::STATE_FRESH_POS +: NCH] = fresh;
      end
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (reg_addr == ive_pkg::ADDR_WORD0 + 4'(i)) begin
            next_rdata = {16'h0000, ive_word(in_word, i)};
          end
        end
      end
    endcase
  end

  // Read data register; zero outside a read.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// File: design/ive_pkg.sv
// Purpose: Shared constants and types of the input value range encoder.
// Assumes: A 25 MHz core clock and a 16-bit two's-complement input word.
// Notes: Register offsets are word indices on the plain register port.
package ive_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Input word codes.
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_RATED_HI = 16'h6c00;
  localparam logic [15:0] CODE_OVER_MAX = 16'h7eff;
  localparam logic [15:0] CODE_OVERFLOW = 16'h7fff;
  localparam logic [15:0] CODE_UNDER_MIN = 16'hed00;
  localparam logic [15:0] CODE_UNDERFLOW = 16'h8000;
  localparam logic [15:0] CODE_SUBST = 16'h7fff;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion cycle timing.
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_CYCLE_US = 250;
  localparam int CONV_CYCLE_CLKS = (CONV_CYCLE_US * 1000) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Register word offsets.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PARAM = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_STATE = 4'h4;
  localparam logic [3:0] ADDR_WORD0 = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_WB_DIAG_POS = 8;
  localparam int CTRL_LIM_DIAG_POS = 9;
  localparam int PARAM_COMMIT_POS = 0;
  localparam int PARAM_BAD_POS = 1;
  localparam int STAT_OPEN_POS = 0;
  localparam int STAT_LOW_POS = 8;
  localparam int STAT_HIGH_POS = 16;
  localparam int STATE_LOAD_POS = 0;
  localparam int STATE_RUN_POS = 1;
  localparam int STATE_PSTATE_POS = 2;
  localparam int STATE_FRESH_POS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // Parameter assignment state of the module.
  typedef enum logic [1:0] {
    IVE_UNASSIGNED,
    IVE_INVALID,
    IVE_ASSIGNED
  } ive_pstate_t;

endpackage

// File: design/ive_scale.sv
// Purpose: Combinational encoding of one converter sample into an input word.
// Assumes: The sample span of the rated range is 2**SPAN_BITS raw counts.
// Notes: Diagnostic enables only shape the code and the event flags.
module ive_scale #(
  parameter int RAW_W = 24,
  parameter int SPAN_BITS = 16
) (
  // Sample.
  input wire logic signed [RAW_W-1:0] raw,
  input wire logic signed [RAW_W-1:0] zero,
  input wire logic wire_break,
  // Diagnostic enables.
  input wire logic wb_diag_en,
  input wire logic lim_diag_en,
  // Result.
  output logic [15:0] code,
  output logic ev_open,
  output logic ev_low,
  output logic ev_high
);

  ////////////////////////////////////////////////////////////////////////////
  logic signed [RAW_W:0] diff;
  logic signed [RAW_W+17:0] prod;
  logic signed [RAW_W+17:0] scaled;
  logic signed [RAW_W+17:0] lim_hi;
  logic signed [RAW_W+17:0] lim_lo;

  // Offset to zero at the low end of the rated range, then scale by the span.
  // The wide product keeps every sample exact before saturation.
  assign diff = {raw[RAW_W-1], raw} - {zero[RAW_W-1], zero};
  assign prod = {{17{diff[RAW_W]}}, diff} * {{(RAW_W+2){1'b0}}, ive_pkg::CODE_RATED_HI};
  assign scaled = prod >>> SPAN_BITS;
  assign lim_hi = {{(RAW_W+2){1'b0}}, ive_pkg::CODE_OVER_MAX};
  assign lim_lo = {{(RAW_W+2){1'b1}}, ive_pkg::CODE_UNDER_MIN};

  // Wire break has priority over range evaluation.
  always_comb begin
    code = scaled[15:0];
    ev_open = 1'b0;
    ev_low = 1'b0;
    ev_high = 1'b0;
    if (wire_break) begin
      if (wb_diag_en) begin
        code = ive_pkg::CODE_OVERFLOW;
        ev_open = 1'b1;
      end else begin
        code = ive_pkg::CODE_UNDERFLOW;
        ev_low = lim_diag_en;
      end
    end else if (scaled > lim_hi) begin
      code = ive_pkg::CODE_OVERFLOW;
      ev_high = lim_diag_en;
    end else if (scaled < lim_lo) begin
      code = ive_pkg::CODE_UNDERFLOW;
      ev_low = lim_diag_en;
    end
  end

endmodule

// File: testbench/ive_conv_model.sv
// Purpose: Converter model that answers each conversion start seen while hold is low with one sample per channel.
// Assumes: The bench sets the raw values and break flags it wants converted.
// Notes: Between samples the raw lines toggle, so every other cycle shows the last value again.
module ive_conv_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Bench control.
  input wire logic hold,
  input wire logic [47:0] set_raw,
  input wire logic [1:0] set_brk,
  // Converter side.
  input wire logic conv_start,
  output logic [1:0] smp_valid,
  output logic [47:0] smp_raw,
  output logic [1:0] smp_wire_break
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dly;
  // A three-cycle delay stands in for the conversion time; hold stalls the converter.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dly <= 3'h0;
      smp_valid <= 2'h0;
      smp_raw <= 48'h0;
      smp_wire_break <= 2'h0;
    end else begin
      dly <= {dly[1:0], conv_start & ~hold};
      smp_valid <= {2{dly[2]}};
      smp_raw <= dly[2] ? set_raw : ~smp_raw;
      smp_wire_break <= dly[2] ? set_brk : 2'h0;
    end
  end
endmodule

// File: testbench/ive_checker.sv
// Purpose: Port-level checks of the input value range encoder.
// Assumes: Channel 0 occupies the low 16 bits of in_word.
// Notes: Counters are saturated or reset so that they never wrap.
module ive_checker #(
  parameter int NCH = 2,
  parameter int CYCLE_CLKS = 6250
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Pins and word path.
  input wire logic load_missing_pin,
  input wire logic conv_start,
  input wire logic [NCH*16-1:0] in_word,
  input wire logic word_update,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int gap;
  int lm_cnt;
  logic seen;
  ////////////////////////////////////////
  // Cycles since the last update, and how long the load pin has stood high.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap <= 0;
      seen <= 1'b0;
      lm_cnt <= 0;
    end else begin
      gap <= word_update ? 0 : gap + 1;
      seen <= seen | word_update;
      lm_cnt <= !load_missing_pin ? 0 : (lm_cnt < 8 ? lm_cnt + 1 : lm_cnt);
    end
  end
  a_update_period: assert property (word_update && seen |-> gap == CYCLE_CLKS - 1)
    else $error("word update period wrong");
  a_word_hold: assert property (!word_update |-> $stable(in_word))
    else $error("input word changed between updates");
  a_update_pulse: assert property (word_update |=> !word_update)
    else $error("word update longer than one cycle");
  a_start_pairs: assert property (word_update |-> conv_start)
    else $error("conversion start missing at update");
  a_load_subst: assert property (word_update && lm_cnt >= 5 |-> in_word == {NCH{16'h7fff}})
    else $error("missing load supply not substituted");
  a_reset_subst: assert property ($fell(rst) |-> in_word == {NCH{16'h7fff}})
    else $error("startup word not substituted");
  a_over_codes: assert property (word_update |-> !(in_word[15:0] inside {[16'h7f00:16'h7ffe]}))
    else $error("code between overshoot limit and overflow");
  a_under_codes: assert property (word_update |-> !in_word[15] || in_word[15:0] >= 16'hed00 ||
    in_word[15:0] == 16'h8000)
    else $error("code between underflow and undershoot limit");
  a_word_read: assert property (reg_rd && reg_addr == 4'h8 |=> reg_rdata[15:0] == $past(in_word[15:0]))
    else $error("word read differs from input word");
endmodule
bind ive_top ive_checker #(.NCH(NCH), .CYCLE_CLKS(CYCLE_CLKS)) chk_u (.core_clk, .rst,
  .load_missing_pin, .conv_start, .in_word, .word_update, .reg_addr, .reg_rd, .reg_rdata);

// File: testbench/test_input_value_range_encoder.sv
// Purpose: Self-checking bench for the input value range encoder.
// Assumes: A shortened conversion cycle of CYC clocks.
// Notes: Each new input is checked two word updates later, when it must have landed.
module test_input_value_range_encoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 20;
  localparam logic [23:0] RZ = 24'h004000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic load_missing_pin = 1'b0;
  logic ctrl_run_pin = 1'b1;
  logic hold = 1'b0;
  logic [47:0] set_raw = 48'h0;
  logic [1:0] set_brk = 2'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] smp_valid, smp_wire_break;
  logic [47:0] smp_raw;
  logic conv_start, word_update, irq;
  logic [31:0] in_word, reg_rdata;
  int failures = 0;
  int n_compared = 0;
  int tab[8] = '{0, 65536, -1, 77064, 77067, -11529, -11530, 49152};
  ive_top #(.CYCLE_CLKS(CYC)) dut_u (.core_clk, .rst, .smp_valid, .smp_raw, .smp_wire_break,
    .conv_start, .load_missing_pin, .ctrl_run_pin, .in_word, .word_update, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  ive_conv_model conv_u (.core_clk, .rst, .hold, .set_raw, .set_brk, .conv_start, .smp_valid,
    .smp_raw, .smp_wire_break);
  ////////////////////////////////////////
  // The clock toggles every half period of 40 ns.
  always #20 core_clk = ~core_clk;
  // Expected code of an offset from 1 V, in raw counts; 65536 counts span the rated range.
  function automatic logic [15:0] enc(input int d);
    int v;
    v = (d * 27648) >>> 16;
    if (v > 32511) return 16'h7fff;
    if (v < -4864) return 16'h8000;
    return v[15:0];
  endfunction
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    cmp("register", e, reg_rdata & m);
  endtask
  task automatic upd(input int n);
    repeat (n) @(negedge core_clk iff word_update === 1'b1);
  endtask
  task automatic set(input int d0, input int d1, input logic [1:0] b);
    @(posedge core_clk);
    set_raw <= {RZ + d1[23:0], RZ + d0[23:0]};
    set_brk <= b;
    upd(2);
  endtask
  task automatic stop_test;
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A hang is cut short well past the expected run of about 850 cycles.
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  // Main sequence of register accesses and conversions.
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    cmp("word", 32'h7fff7fff, in_word);
    rd(ive_pkg::ADDR_CTRL, 32'h0, 32'hffffffff);
    rd(ive_pkg::ADDR_MASK, 32'h0, 32'hffffffff);
    rd(4'h5, 32'h0, 32'hffffffff);
    wr(ive_pkg::ADDR_CTRL, 32'h303);
    set(65536, 49152, 2'h0);
    cmp("word", 32'h7fff7fff, in_word);
    rd(ive_pkg::ADDR_STATE, 32'h3, 32'hf);
    wr(ive_pkg::ADDR_PARAM, 32'h3);
    upd(2);
    cmp("word", 32'h7fff7fff, in_word);
    rd(ive_pkg::ADDR_STATE, 32'h7, 32'hf);
    @(posedge core_clk);
    hold <= 1'b1;
    upd(1);
    wr(ive_pkg::ADDR_PARAM, 32'h1);
    upd(2);
    cmp("word", 32'h7fff7fff, in_word);
    @(posedge core_clk);
    hold <= 1'b0;
    foreach (tab[i]) begin
      set(tab[i], 49152, 2'h0);
      cmp("word", {16'h5100, enc(tab[i])}, in_word);
    end
    rd(ive_pkg::ADDR_STATUS, 32'h10100, 32'h30303);
    wr(ive_pkg::ADDR_STATUS, 32'h30303);
    rd(ive_pkg::ADDR_STATUS, 32'h0, 32'h30303);
    wr(ive_pkg::ADDR_MASK, 32'h1);
    set(0, 49152, 2'h1);
    cmp("word", 32'h51007fff, in_word);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(ive_pkg::ADDR_MASK, 32'h0);
    @(negedge core_clk);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(ive_pkg::ADDR_CTRL, 32'h203);
    wr(ive_pkg::ADDR_STATUS, 32'h30303);
    upd(2);
    cmp("word", 32'h51008000, in_word);
    rd(ive_pkg::ADDR_STATUS, 32'h100, 32'h303);
    wr(ive_pkg::ADDR_MASK, 32'h100);
    @(negedge core_clk);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(ive_pkg::ADDR_CTRL, 32'h003);
    wr(ive_pkg::ADDR_STATUS, 32'h303);
    upd(2);
    cmp("word", 32'h51008000, in_word);
    rd(ive_pkg::ADDR_STATUS, 32'h0, 32'h303);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(ive_pkg::ADDR_CTRL, 32'h303);
    set(65536, 0, 2'h0);
    @(posedge core_clk);
    load_missing_pin <= 1'b1;
    upd(2);
    cmp("word", 32'h7fff7fff, in_word);
    @(posedge core_clk);
    ctrl_run_pin <= 1'b0;
    upd(2);
    cmp("word", 32'h7fff7fff, in_word);
    @(posedge core_clk);
    load_missing_pin <= 1'b0;
    upd(2);
    cmp("word", 32'h00006c00, in_word);
    rd(ive_pkg::ADDR_STATE, 32'h1, 32'h3);
    wr(ive_pkg::ADDR_CTRL, 32'h301);
    upd(2);
    cmp("word", 32'h7fff6c00, in_word);
    rd(ive_pkg::ADDR_WORD0, 32'h6c00, 32'hffff);
    // A sample already waiting when a commit lands must not be delivered.
    upd(1);
    @(posedge core_clk);
    hold <= 1'b1;
    repeat (5) @(posedge core_clk);
    wr(ive_pkg::ADDR_PARAM, 32'h1);
    upd(2);
    cmp("word", 32'h7fff7fff, in_word);
    rd(ive_pkg::ADDR_STATE, 32'h9, 32'h30f);
    stop_test();
  end
endmodule
